// File: core/rpm_pkg.sv
// Purpose: shared constants and types for the receive performance monitor counters
// Assumes: 12-bit register addresses, 8-bit register data
// Notes: registers sit at their byte offsets on the plain register port

//------------------------------------------------------------
// package
//------------------------------------------------------------
package rpm_pkg;

	localparam int RPM_ADDR_W = 12;
	localparam int RPM_DATA_W = 8;
	localparam int RPM_NARROW_W = 8;
	localparam int RPM_WIDE_W = 16;
	localparam int RPM_ALIGN_W = 8;

	// register offsets
	localparam logic [11:0] RPM_LOF_ADDR = 12'h90a;
	localparam logic [11:0] RPM_CFA_ADDR = 12'h90b;
	localparam logic [11:0] RPM_FCS_ADDR = 12'h90c;
	localparam logic [11:0] RPM_PAT_HI_ADDR = 12'h90d;
	localparam logic [11:0] RPM_PAT_LO_ADDR = 12'h90e;
	localparam logic [11:0] RPM_IRQ_STAT_ADDR = 12'h920;
	localparam logic [11:0] RPM_IRQ_MASK_ADDR = 12'h921;

	// reset values
	localparam logic [7:0] RPM_BYTE_RST = 8'h00;
	localparam logic [15:0] RPM_WORD_RST = 16'h0000;

	// interrupt status and mask field positions
	localparam int RPM_EVT_LOF = 0;
	localparam int RPM_EVT_CFA = 1;
	localparam int RPM_EVT_FCS = 2;
	localparam int RPM_EVT_PAT = 3;
	localparam int RPM_EVT_N = 4;
	localparam logic [3:0] RPM_EVT_RST = 4'h0;

	// wide counter read pairing
	typedef enum logic [1:0] {
		RPM_PAIR_IDLE = 2'b01,
		RPM_PAIR_ARMED = 2'b10
	} rpm_pair_state_t;

	function automatic logic rpm_hit(input logic [11:0] addr, input logic [11:0] target);
		rpm_hit = (addr == target);
	endfunction : rpm_hit

endpackage : rpm_pkg

// File: core/rpm_cnt_if.sv
// Purpose: control and value bundle between the monitor and one event counter
// Assumes: single clock domain
// Notes: ctl side drives events and clears, cnt side returns the count
`timescale 1ns/1ns

interface rpm_cnt_if #(parameter int W = 8);
	logic evt;
	logic clr;
	logic sub_en;
	logic [W-1:0] sub_val;
	logic [W-1:0] count;

	modport ctl (output evt, output clr, output sub_en, output sub_val, input count);
	modport cnt (input evt, input clr, input sub_en, input sub_val, output count);
endinterface : rpm_cnt_if

// File: core/rpm_sat_counter.sv
// Purpose: saturating event counter with full clear and partial subtract
// Assumes: sub_val never exceeds the current count
// Notes: an event in the clearing cycle is kept
`timescale 1ns/1ns

module rpm_sat_counter #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	rpm_cnt_if.cnt cif
);

	logic [W-1:0] count_q;
	logic [W-1:0] base;
	logic [W-1:0] count_d;

	//------------------------------------------------------------
	// next count
	//------------------------------------------------------------
	always_comb begin
		if (cif.clr) begin
			base = '0;
		end else if (cif.sub_en) begin
			base = count_q - cif.sub_val;
		end else begin
			base = count_q;
		end
		// hold at all ones rather than wrapping
		if (cif.evt && (base != {W{1'b1}})) begin // [RL11]
			count_d = base + {{(W-1){1'b0}}, 1'b1};
		end else begin
			count_d = base;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign cif.count = count_q;

	a_sat_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		(count_q == {W{1'b1}}) && !cif.clr && !cif.sub_en |=> count_q == {W{1'b1}})
		else $error("counter left all ones without a clear");

	a_clear_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
		cif.clr |=> count_q == {{(W-1){1'b0}}, $past(cif.evt)})
		else $error("clear did not leave only the coincident event");

endmodule : rpm_sat_counter

// File: core/rpm_irq.sv
// Purpose: sticky event status, mask and level interrupt
// Assumes: status bits clear by writing one
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns

module rpm_irq #(
	parameter int N = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [N-1:0] evt_set,
	input wire logic stat_wr,
	input wire logic mask_wr,
	input wire logic [N-1:0] wr_bits,
	output logic [N-1:0] stat_q,
	output logic [N-1:0] mask_q,
	output logic irq_q
);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~(stat_wr ? wr_bits : '0)) | evt_set;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (mask_wr) begin
			mask_q <= wr_bits;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	a_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|evt_set) |=> (stat_q & $past(evt_set)) == $past(evt_set))
		else $error("event lost in status");

	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|(stat_q & mask_q)) |=> irq_q)
		else $error("interrupt not raised for unmasked status");

endmodule : rpm_irq

// File: core/rpm_monitor.sv
// Purpose: receive performance monitor counters with clear-on-read register port
// Assumes: events are synchronous to clk_sys; one read or write strobe at a time
// Notes: read data stand only in the cycle after the read strobe
//
// What this block does
// (RL1) Keep an 8-bit count of loss-of-frame occurrences since the last read.
// (RL2) Count each new loss-of-frame declaration once, not every frame it persists.
// (RL3) Reading a counter clears it, so each value covers events since the last read.
// (RL4) Keep an 8-bit count of frame alignment changes since the last read.
// (RL5) Declare an alignment change when the newly locked alignment differs from the offer.
// (RL6) Keep an 8-bit count of link 1 checksum errors since the last read.
// (RL7) Count pattern bit errors in 16 bits, exposed as upper and lower bytes.
// (RL8) Software reads the upper byte before the lower byte for a consistent value.
// (RL9) The wide counter is cleared only by an upper read followed by a lower read.
// (RL10) Upper read captures the lower byte; the lower read returns that capture.
// (RL11) Counters hold at all ones instead of wrapping.
`timescale 1ns/1ns

module rpm_monitor
	import rpm_pkg::*;
#(
	parameter int ALIGN_W = RPM_ALIGN_W
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [RPM_ADDR_W-1:0] reg_addr,
	input wire logic [RPM_DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	output logic [RPM_DATA_W-1:0] reg_rd_data,
	input wire logic loss_of_frame,
	input wire logic align_lock_strobe,
	input wire logic [ALIGN_W-1:0] locked_align,
	input wire logic [ALIGN_W-1:0] offered_align,
	input wire logic link1_checksum_error,
	input wire logic pattern_bit_error,
	output logic irq
);

	//------------------------------------------------------------
	// counters
	//------------------------------------------------------------
	rpm_cnt_if #(.W(RPM_NARROW_W)) lof_if ();
	rpm_cnt_if #(.W(RPM_NARROW_W)) cfa_if ();
	rpm_cnt_if #(.W(RPM_NARROW_W)) fcs_if ();
	rpm_cnt_if #(.W(RPM_WIDE_W)) pat_if ();

	rpm_sat_counter #(.W(RPM_NARROW_W)) u_lof_cnt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cif(lof_if)
	);

	rpm_sat_counter #(.W(RPM_NARROW_W)) u_cfa_cnt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cif(cfa_if)
	);

	rpm_sat_counter #(.W(RPM_NARROW_W)) u_fcs_cnt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cif(fcs_if)
	);

	rpm_sat_counter #(.W(RPM_WIDE_W)) u_pat_cnt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cif(pat_if)
	);

	//------------------------------------------------------------
	// event detection
	//------------------------------------------------------------
	logic lof_prev_q;
	logic lof_declared;
	logic align_changed;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lof_prev_q <= 1'b0;
		end else begin
			lof_prev_q <= loss_of_frame;
		end
	end

	// count the declaration edge only
	assign lof_declared = loss_of_frame && !lof_prev_q; // [RL2]
	assign align_changed = align_lock_strobe && (locked_align != offered_align); // [RL5]

	//------------------------------------------------------------
	// register decode
	//------------------------------------------------------------
	logic rd_lof;
	logic rd_cfa;
	logic rd_fcs;
	logic rd_pat_hi;
	logic rd_pat_lo;
	logic wr_stat;
	logic wr_mask;

	assign rd_lof = reg_rd_en && rpm_hit(reg_addr, RPM_LOF_ADDR);
	assign rd_cfa = reg_rd_en && rpm_hit(reg_addr, RPM_CFA_ADDR);
	assign rd_fcs = reg_rd_en && rpm_hit(reg_addr, RPM_FCS_ADDR);
	assign rd_pat_hi = reg_rd_en && rpm_hit(reg_addr, RPM_PAT_HI_ADDR);
	assign rd_pat_lo = reg_rd_en && rpm_hit(reg_addr, RPM_PAT_LO_ADDR);
	assign wr_stat = reg_wr_en && rpm_hit(reg_addr, RPM_IRQ_STAT_ADDR);
	assign wr_mask = reg_wr_en && rpm_hit(reg_addr, RPM_IRQ_MASK_ADDR);

	//------------------------------------------------------------
	// wide counter read pairing
	//------------------------------------------------------------
	rpm_pair_state_t pair_q;
	logic [RPM_WIDE_W-1:0] snap_q;
	logic pair_done;

	// lower read only completes the clear once an upper read armed it
	assign pair_done = rd_pat_lo && (pair_q == RPM_PAIR_ARMED); // [RL9]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pair_q <= RPM_PAIR_IDLE;
		end else begin
			case (pair_q)
				RPM_PAIR_IDLE: begin
					if (rd_pat_hi) begin
						pair_q <= RPM_PAIR_ARMED;
					end
				end
				RPM_PAIR_ARMED: begin
					if (rd_pat_lo) begin
						pair_q <= RPM_PAIR_IDLE;
					end
				end
				default: begin
					pair_q <= RPM_PAIR_IDLE;
				end
			endcase
		end
	end

	// snapshot the whole count so both bytes describe one instant
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			snap_q <= RPM_WORD_RST;
		end else if (rd_pat_hi) begin
			snap_q <= pat_if.count; // [RL10]
		end
	end

	//------------------------------------------------------------
	// counter controls
	//------------------------------------------------------------
	assign lof_if.evt = lof_declared; // [RL1]
	assign lof_if.clr = rd_lof; // [RL3]
	assign lof_if.sub_en = 1'b0;
	assign lof_if.sub_val = lof_if.count;

	assign cfa_if.evt = align_changed; // [RL4]
	assign cfa_if.clr = rd_cfa; // [RL3]
	assign cfa_if.sub_en = 1'b0;
	assign cfa_if.sub_val = cfa_if.count;

	assign fcs_if.evt = link1_checksum_error; // [RL6]
	assign fcs_if.clr = rd_fcs; // [RL3]
	assign fcs_if.sub_en = 1'b0;
	assign fcs_if.sub_val = fcs_if.count;

	// events after the upper read survive the clear
	assign pat_if.evt = pattern_bit_error; // [RL7]
	assign pat_if.clr = 1'b0;
	assign pat_if.sub_en = pair_done; // [RL9]
	assign pat_if.sub_val = snap_q;

	//------------------------------------------------------------
	// interrupts
	//------------------------------------------------------------
	logic [RPM_EVT_N-1:0] evt_set;
	logic [RPM_EVT_N-1:0] stat_q;
	logic [RPM_EVT_N-1:0] mask_q;
	logic irq_q;

	always_comb begin
		evt_set = RPM_EVT_RST;
		evt_set[RPM_EVT_LOF] = lof_declared;
		evt_set[RPM_EVT_CFA] = align_changed;
		evt_set[RPM_EVT_FCS] = link1_checksum_error;
		evt_set[RPM_EVT_PAT] = pattern_bit_error;
	end

	rpm_irq #(.N(RPM_EVT_N)) u_irq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.evt_set(evt_set),
		.stat_wr(wr_stat),
		.mask_wr(wr_mask),
		.wr_bits(reg_wr_data[RPM_EVT_N-1:0]),
		.stat_q(stat_q),
		.mask_q(mask_q),
		.irq_q(irq_q)
	);

	assign irq = irq_q;

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	logic [RPM_DATA_W-1:0] rd_data_d;
	logic [RPM_DATA_W-1:0] rd_data_q;

	always_comb begin
		rd_data_d = RPM_BYTE_RST;
		if (reg_rd_en) begin
			case (reg_addr)
				RPM_LOF_ADDR: rd_data_d = lof_if.count;
				RPM_CFA_ADDR: rd_data_d = cfa_if.count;
				RPM_FCS_ADDR: rd_data_d = fcs_if.count;
				RPM_PAT_HI_ADDR: rd_data_d = pat_if.count[15:8]; // [RL7]
				RPM_PAT_LO_ADDR: begin
					if (pair_q == RPM_PAIR_ARMED) begin
						rd_data_d = snap_q[7:0]; // [RL10]
					end else begin
						rd_data_d = pat_if.count[7:0];
					end
				end
				RPM_IRQ_STAT_ADDR: rd_data_d = {{(RPM_DATA_W-RPM_EVT_N){1'b0}}, stat_q};
				RPM_IRQ_MASK_ADDR: rd_data_d = {{(RPM_DATA_W-RPM_EVT_N){1'b0}}, mask_q};
				default: rd_data_d = RPM_BYTE_RST;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= RPM_BYTE_RST;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign reg_rd_data = rd_data_q;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	a_lof_edge_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL1]
		loss_of_frame && !lof_prev_q && !rd_lof && (lof_if.count != 8'hff)
		|=> lof_if.count == 8'($past(lof_if.count) + 8'h01))
		else $error("loss of frame declaration not counted once");

	a_lof_persist: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
		loss_of_frame && lof_prev_q && !rd_lof |=> $stable(lof_if.count))
		else $error("persisting loss of frame counted again");

	a_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
		rd_cfa |=> (rd_data_q == $past(cfa_if.count)) && (cfa_if.count <= 8'h01))
		else $error("alignment change count not returned and cleared");

	a_cfa_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL4]
		align_changed && !rd_cfa && (cfa_if.count != 8'hff)
		|=> cfa_if.count == 8'($past(cfa_if.count) + 8'h01))
		else $error("alignment change not counted");

	a_cfa_same_align: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
		align_lock_strobe && (locked_align == offered_align) && !rd_cfa
		|=> $stable(cfa_if.count))
		else $error("unchanged alignment counted");

	a_fcs_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
		link1_checksum_error && !rd_fcs && (fcs_if.count != 8'hff)
		|=> fcs_if.count == 8'($past(fcs_if.count) + 8'h01))
		else $error("checksum error not counted");

	a_pat_upper: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		rd_pat_hi |=> rd_data_q == $past(pat_if.count[15:8]))
		else $error("upper pattern byte wrong");

	a_pat_pair_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		pair_done && !pattern_bit_error
		|=> pat_if.count == 16'($past(pat_if.count) - $past(snap_q)))
		else $error("ordered pair did not clear the pattern count");

	a_pat_lone_lower: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		rd_pat_lo && (pair_q == RPM_PAIR_IDLE) && !pattern_bit_error
		|=> $stable(pat_if.count))
		else $error("lower read alone changed the pattern count");

	a_pat_lower_snap: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL10]
		rd_pat_hi ##1 rd_pat_lo |=> rd_data_q == $past(pat_if.count[7:0], 2))
		else $error("lower byte not from the upper read instant");

	a_pair_arms: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL10]
		rd_pat_hi |=> (pair_q == RPM_PAIR_ARMED) && (snap_q == $past(pat_if.count)))
		else $error("upper read did not arm and snapshot");

	a_pair_disarms: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		pair_done |=> pair_q == RPM_PAIR_IDLE)
		else $error("paired lower read left the pair armed");

	a_pat_hi_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		rd_pat_hi && !pattern_bit_error |=> $stable(pat_if.count))
		else $error("upper read alone changed the pattern count");

	a_pat_event_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		pattern_bit_error && !pair_done && (pat_if.count != 16'hffff)
		|=> pat_if.count == 16'($past(pat_if.count) + 16'h0001))
		else $error("pattern bit error not counted");

	a_pat_sat_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		(pat_if.count == 16'hffff) && !pair_done |=> pat_if.count == 16'hffff)
		else $error("pattern count wrapped");

	a_lof_sat_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		(lof_if.count == 8'hff) && !rd_lof |=> lof_if.count == 8'hff)
		else $error("loss of frame count wrapped");

	a_cfa_sat_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		(cfa_if.count == 8'hff) && !rd_cfa |=> cfa_if.count == 8'hff)
		else $error("alignment change count wrapped");

	a_lof_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
		!loss_of_frame && !rd_lof |=> $stable(lof_if.count))
		else $error("loss of frame count moved without a declaration");

	a_cfa_no_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
		!align_lock_strobe && !rd_cfa |=> $stable(cfa_if.count))
		else $error("alignment change counted without a lock");

	a_fcs_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
		!link1_checksum_error && !rd_fcs |=> $stable(fcs_if.count))
		else $error("checksum count moved without an error");

	a_lof_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
		rd_lof |=> (rd_data_q == $past(lof_if.count)) && (lof_if.count <= 8'h01))
		else $error("loss of frame count not returned and cleared");

	a_fcs_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
		rd_fcs |=> (rd_data_q == $past(fcs_if.count)) && (fcs_if.count <= 8'h01))
		else $error("checksum count not returned and cleared");

	a_rd_idle_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!reg_rd_en |=> rd_data_q == RPM_BYTE_RST)
		else $error("read data not zero outside a read");

	a_irq_masked_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(stat_q & mask_q) == RPM_EVT_RST |=> !irq)
		else $error("interrupt high with nothing unmasked");

endmodule : rpm_monitor

// File: dv/rpm_evt_src.sv
// Purpose: far-side model of framer, link 1 and pattern checker events
// Assumes: events are synchronous to clk_sys
// Notes: the bench calls the tasks; outputs change by nba at rising edges
`timescale 1ns/1ns

module rpm_evt_src
	import rpm_pkg::*;
(
	input wire logic clk_sys,
	output logic loss_of_frame,
	output logic align_lock_strobe,
	output logic [RPM_ALIGN_W-1:0] locked_align,
	output logic [RPM_ALIGN_W-1:0] offered_align,
	output logic link1_checksum_error,
	output logic pattern_bit_error
);
	initial begin
		loss_of_frame = 1'b0;
		align_lock_strobe = 1'b0;
		locked_align = 8'h00;
		offered_align = 8'hff;
		link1_checksum_error = 1'b0;
		pattern_bit_error = 1'b0;
	end

	// one declaration that persists for n cycles
	task automatic lof_hold(input int n);
		@(posedge clk_sys);
		loss_of_frame <= 1'b1;
		repeat (n) @(posedge clk_sys);
		loss_of_frame <= 1'b0;
	endtask : lof_hold

	// alignment fields are meaningless outside the strobe, so they are scrambled
	task automatic lock(input logic [7:0] l, input logic [7:0] o);
		@(posedge clk_sys);
		align_lock_strobe <= 1'b1;
		locked_align <= l;
		offered_align <= o;
		@(posedge clk_sys);
		align_lock_strobe <= 1'b0;
		locked_align <= ~l;
		offered_align <= ~o;
	endtask : lock

	task automatic fcs(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			link1_checksum_error <= 1'b1;
		end
		@(posedge clk_sys);
		link1_checksum_error <= 1'b0;
	endtask : fcs

	task automatic pat(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pattern_bit_error <= 1'b1;
		end
		@(posedge clk_sys);
		pattern_bit_error <= 1'b0;
	endtask : pat
endmodule : rpm_evt_src

// File: dv/tb.sv
// Purpose: self-checking bench for the performance monitor counters
// Assumes: plain register port, read data in the cycle after the strobe
// Notes: event stimulus comes from the far-side model u_src
`timescale 1ns/1ns

module tb
	import rpm_pkg::*;
;
	logic clk_sys, rst_n, reg_wr_en, reg_rd_en, irq, lof, als, l1e, pbe;
	logic [RPM_ADDR_W-1:0] reg_addr;
	logic [RPM_DATA_W-1:0] reg_wr_data, reg_rd_data, d;
	logic [RPM_ALIGN_W-1:0] lk, ofr;
	int n_fail, n_compared;

	rpm_monitor u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .loss_of_frame(lof), .align_lock_strobe(als),
		.locked_align(lk), .offered_align(ofr), .link1_checksum_error(l1e),
		.pattern_bit_error(pbe), .irq(irq));
	rpm_evt_src u_src (.clk_sys(clk_sys), .loss_of_frame(lof), .align_lock_strobe(als),
		.locked_align(lk), .offered_align(ofr), .link1_checksum_error(l1e),
		.pattern_bit_error(pbe));

	//------------------------------------------------------------
	// bus and compare tasks
	//------------------------------------------------------------
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1 d = reg_rd_data;
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask : wr

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk8

	task automatic irq_after(input logic exp);
		repeat (3) @(posedge clk_sys);
		#1 chk8({7'h00, irq}, {7'h00, exp}, "irq level");
	endtask : irq_after

	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_reset();
		logic [11:0] al [8];
		al = '{12'h90a, 12'h90b, 12'h90c, 12'h90d, 12'h90e, 12'h920, 12'h921, 12'h9ff};
		foreach (al[i]) begin
			rd(al[i]);
			chk8(d, 8'h00, "reset value");
		end
		$display("test reset done");
	endtask : t_reset

	task automatic t_lof();
		u_src.lof_hold(6);
		u_src.lof_hold(1);
		rd(RPM_LOF_ADDR);
		chk8(d, 8'h02, "lof count");
		rd(RPM_LOF_ADDR);
		chk8(d, 8'h00, "lof after read");
		$display("test lof done");
	endtask : t_lof

	task automatic t_align();
		u_src.lock(8'h3c, 8'h3c);
		u_src.lock(8'h3c, 8'h5a);
		u_src.lock(8'h01, 8'h00);
		rd(RPM_CFA_ADDR);
		chk8(d, 8'h02, "align count");
		rd(RPM_CFA_ADDR);
		chk8(d, 8'h00, "align after read");
		$display("test align done");
	endtask : t_align

	task automatic t_fcs();
		u_src.fcs(3);
		wr(RPM_FCS_ADDR, 8'h55);
		rd(RPM_FCS_ADDR);
		chk8(d, 8'h03, "fcs count");
		u_src.fcs(300);
		rd(RPM_FCS_ADDR);
		chk8(d, 8'hff, "fcs saturation");
		rd(RPM_FCS_ADDR);
		chk8(d, 8'h00, "fcs after read");
		// read and error land on the same edge
		fork
			rd(RPM_FCS_ADDR);
			u_src.fcs(1);
		join
		chk8(d, 8'h00, "read with event");
		rd(RPM_FCS_ADDR);
		chk8(d, 8'h01, "event kept by clear");
		$display("test fcs done");
	endtask : t_fcs

	task automatic t_pat();
		u_src.pat(291);
		rd(RPM_PAT_LO_ADDR);
		chk8(d, 8'h23, "lower alone");
		rd(RPM_PAT_HI_ADDR);
		chk8(d, 8'h01, "upper byte");
		u_src.pat(2);
		rd(RPM_PAT_LO_ADDR);
		chk8(d, 8'h23, "lower snapshot");
		rd(RPM_PAT_HI_ADDR);
		chk8(d, 8'h00, "upper after pair");
		rd(RPM_PAT_LO_ADDR);
		chk8(d, 8'h02, "events kept");
		rd(RPM_PAT_HI_ADDR);
		rd(RPM_PAT_LO_ADDR);
		chk8(d, 8'h00, "pattern cleared");
		$display("test pattern done");
	endtask : t_pat

	task automatic t_irq();
		rd(RPM_IRQ_STAT_ADDR);
		chk8(d, 8'h0f, "status all set");
		irq_after(1'b0);
		wr(RPM_IRQ_MASK_ADDR, 8'h08);
		irq_after(1'b1);
		wr(RPM_IRQ_STAT_ADDR, 8'h08);
		irq_after(1'b0);
		rd(RPM_IRQ_STAT_ADDR);
		chk8(d, 8'h07, "status after clear");
		wr(RPM_IRQ_MASK_ADDR, 8'h0f);
		irq_after(1'b1);
		wr(RPM_IRQ_STAT_ADDR, 8'h07);
		irq_after(1'b0);
		rd(RPM_IRQ_MASK_ADDR);
		chk8(d, 8'h0f, "mask readback");
		$display("test irq done");
	endtask : t_irq

	//------------------------------------------------------------
	// run control
	//------------------------------------------------------------
	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end

	initial begin
		n_fail = 0;
		n_compared = 0;
		rst_n = 1'b0;
		reg_addr = 12'h000;
		reg_wr_data = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_lof();
		t_align();
		t_fcs();
		t_pat();
		t_irq();
		wrap_up();
	end
endmodule : tb
